// ---- rtl/dprc_top.sv ----
// Purpose: Phase detector range configuration register with its phase path
// Assumes: APB slave, single clock, phase error in signed fixed point UI
// Notes: Outputs lag a register write by two cycles through the decoder
//
// Functional notes
// - Bit 6 set switches the wide-range phase detector on; clear switches it off.
// - Wide detector on keeps tracking multi-UI drift at direct input rate up to 77.76 MHz.
// - Wide detector tracking range comes from the 4-bit window code, bits 3 to 0.
// - Bit 5 clear limits DPLL phase error to plus or minus one UI.
// - Window is +-(2^(code+1)-1) UI; codes 1100 to 1111 give +-8191 UI.
// - Reset loads 1110 0101: loss trigger, wide detector, multi-cycle, +-63 UI.
// - Bit 7 set declares phase loss when error exceeds window; clear never triggers.
`include "dprc_consts.svh"

module dprc_top #(
    parameter int INT_BITS = 14,
    parameter int FRAC_BITS = 8
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [`DPRC_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic signed [INT_BITS+FRAC_BITS-1:0] phase_err_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    output logic coarse_loss_en_out,
    output logic wide_range_en_out,
    output logic multi_cycle_result_use_out,
    output logic [`DPRC_LIM_W-1:0] window_limit_out,
    output logic signed [INT_BITS+FRAC_BITS-1:0] dpll_phase_err_out,
    output logic signed [INT_BITS+FRAC_BITS-1:0] tracked_phase_out,
    output logic phase_loss_out
);

    localparam int W = INT_BITS + FRAC_BITS;

    ////////////////////////////////////////////////////////////////
    // Register bank and APB handshake
    dprc_pkg::dprc_bus_state_t state, next_state;
    logic [7:0] cfg, next_cfg;
    logic next_pready;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic addr_hit;

    assign addr_hit = (paddr_in == `DPRC_CFG_ADDR);

    always_comb begin
        next_state = state;
        next_cfg = cfg;
        next_pready = 1'b0;
        next_prdata = `DPRC_WORD_ZERO;
        next_pslverr = 1'b0;
        unique case (state)
            dprc_pkg::ST_IDLE: begin
                // Answer one cycle after setup; no wait states needed
                if (psel_in && !penable_in) begin
                    next_state = dprc_pkg::ST_RESP;
                    next_pready = 1'b1;
                    next_pslverr = !addr_hit;
                    if (addr_hit && !pwrite_in) begin
                        next_prdata = {`DPRC_RD_PAD, cfg};
                    end
                end
            end
            dprc_pkg::ST_RESP: begin
                next_state = dprc_pkg::ST_IDLE;
                if (psel_in && penable_in && pwrite_in && addr_hit && pstrb_in[0]) begin
                    next_cfg = pwdata_in[7:0];
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= dprc_pkg::ST_IDLE;
            cfg <= `DPRC_CFG_RESET;
            pready_out <= 1'b0;
            prdata_out <= `DPRC_WORD_ZERO;
            pslverr_out <= 1'b0;
        end else begin
            state <= next_state;
            cfg <= next_cfg;
            pready_out <= next_pready;
            prdata_out <= next_prdata;
            pslverr_out <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Window decode
    logic [`DPRC_LIM_W-1:0] win_lim;

    dprc_window_dec u_win (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .code_in(cfg[`DPRC_CODE_HI:`DPRC_CODE_LO]),
        .limit_out(win_lim)
    );

    ////////////////////////////////////////////////////////////////
    // Phase path
    function automatic logic signed [W-1:0] clamp_err(input logic signed [W-1:0] err,
                                                      input logic [W-1:0] lim);
        logic [W-1:0] mag;
        mag = err[W-1] ? W'(-err) : err;
        if (mag > lim) begin
            clamp_err = err[W-1] ? W'(-lim) : lim;
        end else begin
            clamp_err = err;
        end
    endfunction

    logic [W-1:0] err_mag;
    logic [W-1:0] win_fix;
    logic [W-1:0] one_ui;
    logic [W-1:0] track_lim;
    logic next_loss_en, next_wide, next_multi, next_loss;
    logic [`DPRC_LIM_W-1:0] next_win;
    logic signed [W-1:0] next_dpll, next_track;

    assign err_mag = phase_err_in[W-1] ? W'(-phase_err_in) : phase_err_in;
    assign win_fix = W'({win_lim, {FRAC_BITS{1'b0}}});
    assign one_ui = W'({`DPRC_LIM_ONE, {FRAC_BITS{1'b0}}});

    always_comb begin
        next_loss_en = cfg[`DPRC_BIT_LOSS_EN];
        next_wide = cfg[`DPRC_BIT_WIDE_EN];
        next_multi = cfg[`DPRC_BIT_MULTI];
        next_win = win_lim;
        // Without the wide detector only one cycle of drift can be held
        track_lim = cfg[`DPRC_BIT_WIDE_EN] ? win_fix : one_ui;
        next_track = clamp_err(phase_err_in, track_lim);
        // Multi-cycle use relies on the wide detector producing the measurement
        if (cfg[`DPRC_BIT_MULTI]) begin
            next_dpll = next_track;
        end else begin
            next_dpll = clamp_err(phase_err_in, one_ui);
        end
        next_loss = cfg[`DPRC_BIT_LOSS_EN] && (err_mag > win_fix);
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            coarse_loss_en_out <= 1'b0;
            wide_range_en_out <= 1'b0;
            multi_cycle_result_use_out <= 1'b0;
            window_limit_out <= '0;
            dpll_phase_err_out <= '0;
            tracked_phase_out <= '0;
            phase_loss_out <= 1'b0;
        end else begin
            coarse_loss_en_out <= next_loss_en;
            wide_range_en_out <= next_wide;
            multi_cycle_result_use_out <= next_multi;
            window_limit_out <= next_win;
            dpll_phase_err_out <= next_dpll;
            tracked_phase_out <= next_track;
            phase_loss_out <= next_loss;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    logic seen_write;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            seen_write <= 1'b0;
        end else if (state == dprc_pkg::ST_RESP && pwrite_in) begin
            seen_write <= 1'b1;
        end
    end

    reset_value_a: assert property (!seen_write |-> cfg == `DPRC_CFG_RESET)
        else $error("Config lost its reset value without a write");
    // Outputs still show reset values one edge after release
    wide_follow_a: assert property ($past(rstn_in) |-> wide_range_en_out == $past(cfg[`DPRC_BIT_WIDE_EN]))
        else $error("Wide enable output does not follow its bit");
    fine_clamp_a: assert property (!$past(cfg[`DPRC_BIT_MULTI]) |->
        (dpll_phase_err_out <= $signed(one_ui) && dpll_phase_err_out >= -$signed(one_ui)))
        else $error("DPLL error exceeds one UI with multi-cycle off");
    multi_pass_a: assert property ($past(cfg[`DPRC_BIT_MULTI]) |-> dpll_phase_err_out == tracked_phase_out)
        else $error("DPLL error is not the coarse measurement");
    track_range_a: assert property (!$past(cfg[`DPRC_BIT_WIDE_EN]) |->
        (tracked_phase_out <= $signed(one_ui) && tracked_phase_out >= -$signed(one_ui)))
        else $error("Tracking exceeds one UI with wide detector off");
    window_code_a: assert property ($past(rstn_in) ##0 $stable(cfg) [*2] |->
        window_limit_out == (cfg[`DPRC_CODE_HI:`DPRC_CODE_LO] >= `DPRC_CODE_SAT ? `DPRC_LIM_MAX :
        `DPRC_LIM_MAX >> (`DPRC_CODE_SAT - cfg[`DPRC_CODE_HI:`DPRC_CODE_LO])))
        else $error("Window limit does not match code");
    loss_on_a: assert property ($past(rstn_in) && cfg[`DPRC_BIT_LOSS_EN] && err_mag > win_fix |=> phase_loss_out)
        else $error("Phase loss missed");
    loss_off_a: assert property (!cfg[`DPRC_BIT_LOSS_EN] |=> !phase_loss_out)
        else $error("Phase loss raised while disabled");
    bus_answer_a: assert property (psel_in && !penable_in && state == dprc_pkg::ST_IDLE |=>
        pready_out ##1 !pready_out)
        else $error("APB answer not one cycle wide");

    write_cov_c: cover property (state == dprc_pkg::ST_RESP && pwrite_in && addr_hit);
    loss_cov_c: cover property (phase_loss_out);
    fine_cov_c: cover property (!multi_cycle_result_use_out && err_mag > one_ui);
    err_cov_c: cover property (pslverr_out);

endmodule

// ---- rtl/dprc_consts.svh ----
// Purpose: Named constants for the phase range configuration block
// Assumes: Included by bare name from the top, window decoder and bench files
// Notes: Offsets, widths, field positions, reset value, code limits and fill words only
`ifndef DPRC_CONSTS_SVH
`define DPRC_CONSTS_SVH

`define DPRC_ADDR_W 12
`define DPRC_CFG_ADDR 12'h074
`define DPRC_CFG_RESET 8'hE5
`define DPRC_BIT_LOSS_EN 7
`define DPRC_BIT_WIDE_EN 6
`define DPRC_BIT_MULTI 5
`define DPRC_CODE_HI 3
`define DPRC_CODE_LO 0
`define DPRC_CODE_SAT 4'hC
`define DPRC_LIM_W 13
`define DPRC_LIM_MAX 13'h1FFF
`define DPRC_LIM_ONE 13'h0001
`define DPRC_RD_PAD 24'h000000
`define DPRC_WORD_ZERO 32'h00000000

`endif

// ---- rtl/dprc_pkg.sv ----
// Purpose: Types shared by the phase range configuration block
// Assumes: Nothing is imported; users write dprc_pkg::name
// Notes: Bus handshake states are one-hot
package dprc_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } dprc_bus_state_t;
endpackage

// ---- rtl/dprc_window_dec.sv ----
// Purpose: Turns the 4-bit coarse window code into a UI limit
// Assumes: Code is stable in the register bank; one cycle of latency is fine
// Notes: Result comes out of a flip-flop
`include "dprc_consts.svh"

module dprc_window_dec (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] code_in,
    output logic [`DPRC_LIM_W-1:0] limit_out
);

    ////////////////////////////////////////////////////////////////
    // Limit of +-(2^(code+1)-1) UI, saturating at 8191
    function automatic logic [`DPRC_LIM_W-1:0] window_limit(input logic [3:0] code);
        if (code >= `DPRC_CODE_SAT) begin
            window_limit = `DPRC_LIM_MAX;
        end else begin
            window_limit = `DPRC_LIM_MAX >> (`DPRC_CODE_SAT - code);
        end
    endfunction

    // Reset branch needs a plain constant, so decode the default code here
    localparam logic [7:0] RST_CFG = `DPRC_CFG_RESET;
    localparam logic [3:0] RST_CODE = RST_CFG[`DPRC_CODE_HI:`DPRC_CODE_LO];
    localparam logic [`DPRC_LIM_W-1:0] RST_LIMIT = window_limit(RST_CODE);

    logic [`DPRC_LIM_W-1:0] next_limit;

    always_comb begin
        next_limit = window_limit(code_in);
    end

    // Reset value matches the decoded default code
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            limit_out <= RST_LIMIT;
        end else begin
            limit_out <= next_limit;
        end
    end

endmodule

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for the phase range configuration register
// Assumes: Zero-wait APB slave; outputs settle within two cycles of a write
// Notes: Random values come from an LFSR that starts at 32'hAEF8
`include "dprc_consts.svh"

module tb;
timeunit 1ns;
timeprecision 1ps;
////////////////////////////////////////////////////////////////////////////////
logic clk_in = 1'b0;
logic rstn_in = 1'b0;
logic psel_in = 1'b0;
logic penable_in = 1'b0;
logic pwrite_in = 1'b0;
logic [`DPRC_ADDR_W-1:0] paddr_in = 12'h000;
logic [31:0] pwdata_in = 32'h00000000;
logic [3:0] pstrb_in = 4'h0;
logic signed [21:0] phase_err_in = 22'h000000;
logic pready_out, pslverr_out, loss_en, wide_en, multi_en, phase_loss_out;
logic [31:0] prdata_out;
logic [`DPRC_LIM_W-1:0] window_limit_out;
logic signed [21:0] dpll_out, tracked_out;
logic [31:0] lfsr = 32'h0000AEF8;
logic [31:0] rd;
logic err;
int fail_count = 0;
int checked = 0;

dprc_top dut_u (
    .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .phase_err_in(phase_err_in), .pready_out(pready_out), .prdata_out(prdata_out),
    .pslverr_out(pslverr_out), .coarse_loss_en_out(loss_en), .wide_range_en_out(wide_en),
    .multi_cycle_result_use_out(multi_en), .window_limit_out(window_limit_out),
    .dpll_phase_err_out(dpll_out), .tracked_phase_out(tracked_out), .phase_loss_out(phase_loss_out)
);

initial begin
    forever #5 clk_in = ~clk_in;
end
////////////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction

function automatic int win_ui(input int c);
    return (c >= 12) ? 8191 : (1 << (c + 1)) - 1;
endfunction

function automatic int clampv(input int v, input int lim);
    return (v > lim) ? lim : ((v < -lim) ? -lim : v);
endfunction

task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
        fail_count++;
        $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
endtask

// Holds the request until pready is seen high at a rising edge or 16 edges pass
task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    logic got;
    got = 1'b0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= s;
    @(posedge clk_in);
    penable_in <= 1'b1;
    for (n = 0; n < 16 && !got; n++) begin
        @(posedge clk_in);
        if (pready_out === 1'b1) begin
            got = 1'b1;
            rd = prdata_out;
            err = pslverr_out;
        end
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    check("pready", 32'h1, {31'h0, got});
endtask

task automatic run_cfg(input logic [7:0] cfg);
    int w, e, lim, k;
    w = win_ui(cfg[3:0]);
    lim = cfg[6] ? w * 256 : 256;
    apb(1'b1, `DPRC_CFG_ADDR, {24'h000000, cfg}, 4'h1);
    apb(1'b0, `DPRC_CFG_ADDR, 32'h0, 4'h0);
    check("readback", {24'h000000, cfg}, rd);
    repeat (2) @(posedge clk_in);
    #1;
    check("window", w, window_limit_out);
    check("wide", cfg[6], wide_en);
    check("loss_en", cfg[7], loss_en);
    check("multi", cfg[5], multi_en);
    for (k = 0; k < 4; k++) begin
        lfsr = next_rand(lfsr);
        // Window edge, one past it, just over 1 UI, then random
        e = (k == 0) ? w * 256 : (k == 1) ? -(w * 256 + 1) : (k == 2) ? 300 : $signed(lfsr[21:0]);
        @(posedge clk_in);
        phase_err_in <= e[21:0];
        repeat (2) @(posedge clk_in);
        #1;
        check("tracked", clampv(e, lim), tracked_out);
        check("dpll", cfg[5] ? clampv(e, lim) : clampv(e, 256), dpll_out);
        check("phase_loss", cfg[7] && (e > w * 256 || -e > w * 256), phase_loss_out);
    end
    $display("[TEST] config %h done", cfg);
endtask

task automatic print_verdict();
    $display("[DONE] checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    #200000;
    fail_count++;
    print_verdict();
end

initial begin
    int k;
    logic [2:0] top;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    check("rst_window", 32'd63, window_limit_out);
    check("rst_flags", 32'h7, {loss_en, wide_en, multi_en});
    apb(1'b0, `DPRC_CFG_ADDR, 32'h0, 4'h0);
    check("rst_value", 32'h000000E5, rd);
    check("mapped_err", 32'h0, {31'h0, err});
    // Unmapped write and masked write must leave the value alone
    apb(1'b1, 12'h078, 32'h00000000, 4'hF);
    check("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b1, `DPRC_CFG_ADDR, 32'h00000000, 4'h0);
    apb(1'b0, `DPRC_CFG_ADDR, 32'h0, 4'h0);
    check("kept_value", 32'h000000E5, rd);
    $display("[TEST] reset and refusals done");
    for (k = 0; k < 32; k++) begin
        lfsr = next_rand(lfsr);
        top = (k < 16) ? k[2:0] : lfsr[7:5];
        top[1] = top[1] | top[0];
        run_cfg({top, 1'b0, k[3:0]});
    end
    // Second reset in mid-run restores the default
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    apb(1'b0, `DPRC_CFG_ADDR, 32'h0, 4'h0);
    check("rerst_value", 32'h000000E5, rd);
    #1;
    check("rerst_window", 32'd63, window_limit_out);
    check("rerst_flags", 32'h7, {loss_en, wide_en, multi_en});
    $display("[TEST] second reset done");
    print_verdict();
end
endmodule
